/* hdl/cdfe_top.sv */
// Counter input front end: pin sync, edge select, debounce, mapped
// channel, start of scan, terminal count and tick timebase, 4 channels
// Assumes ACQ_RUN, SCAN_PERIOD and configuration are on CORE_CLK
//
// Contract
// - Sixteen debounce times, 500 ns to 25.5 ms
// - Optional per-channel input inversion selects edge
// - Bypass ignores debounce time, keeps edge select
// - Settle mode: pass level after full hold
// - Settle mode: short disturbances give no output
// - Pass mode: accepted edge passes at once
// - Pass mode: edge accepted only after stability
// - Pass mode: after stability output equals input
// - Gate: count only while mapped signal high
// - Each counter muxes one of four channels
// - Mapped signal may gate or clear counter
// - Start-of-scan pulses once per scan period
// - Start-of-scan clears counters and latches value
// - Terminal count at 65535 or 4294967295 only
// - Optional stop at top, no wrap
// - Four tick sizes for time measurement
// - Ticks derived from 48 MHz clock period
// - Time measurements count elapsed ticks
// - First scan zeroes every counter
`timescale 1ns/1ps
`default_nettype none
`include "cdfe_defines.svh"

module cdfe_top
#(
  parameter int DB_MIN_CYC =
    (`CDFE_DB_MIN_NS + `CDFE_CLK_NS - 1) / `CDFE_CLK_NS,
  parameter int DB_MAX_CYC =
    (`CDFE_DB_MAX_NS + `CDFE_CLK_NS - 1) / `CDFE_CLK_NS
)
(
  input  wire logic                                CORE_CLK,
  input  wire logic                                RST,
  input  wire logic [3:0]                          CH_PIN,
  input  wire cdfe_pkg::cdfe_ch_cfg_type [3:0]     CH_CFG,
  input  wire cdfe_pkg::cdfe_ctr_cfg_type [3:0]    CTR_CFG,
  input  wire logic                                ACQ_RUN,
  input  wire logic [31:0]                         SCAN_PERIOD,
  output logic [3:0]                               DEB_OUT,
  output logic                                     SOS_PULSE,
  output logic [3:0][31:0]                         CTR_VALUE,
  output logic [3:0][31:0]                         CTR_SNAP,
  output logic [3:0]                               SNAP_STB,
  output logic [3:0]                               TERM_CNT
);

  // ****************************************************************
  // Timebase
  // ****************************************************************
  // Tick k is 10**k periods of the 48 MHz reference, floored to core
  // cycles; the shortest tick is coarser than intended at 20 MHz
  function automatic int tick_cyc(input int k);
    int p;
    int c;
    p = 1;
    for (int j = 0; j < k; j++)
      p = p * 10;
    c = (p * 1000) / (`CDFE_SYS_MHZ * `CDFE_CLK_NS);
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0][`CDFE_TICK_W-1:0] TICK_LIM = {
    `CDFE_TICK_W'(tick_cyc(3)), `CDFE_TICK_W'(tick_cyc(2)),
    `CDFE_TICK_W'(tick_cyc(1)), `CDFE_TICK_W'(tick_cyc(0))};

  cdfe_pkg::cdfe_top_state_type s_q;
  cdfe_pkg::cdfe_top_state_type s_d;
  logic [3:0]                   deb;
  logic [3:0]                   din;
  logic [3:0][`CDFE_DB_W-1:0]   limit;
  logic [3:0]                   map_w;
  logic [3:0]                   hold_w;
  logic [3:0]                   clr_w;

  // ****************************************************************
  // Debounce per channel
  // ****************************************************************
  for (genvar g = 0; g < `CDFE_CHANNELS; g++)
  begin : g_ch
    assign din[g] = s_q.sync2[g] ^ CH_CFG[g].invert;
    assign limit[g] = (CH_CFG[g].db_sel == `CDFE_DB_LAST) ?
      `CDFE_DB_W'(DB_MAX_CYC) :
      `CDFE_DB_W'(DB_MIN_CYC << CH_CFG[g].db_sel);
    cdfe_debounce u_db
    (
      .clk      (CORE_CLK),
      .rst      (RST),
      .din_i    (din[g]),
      .bypass_i (CH_CFG[g].bypass),
      .mode_i   (CH_CFG[g].mode),
      .limit_i  (limit[g]),
      .out_o    (deb[g])
    );
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic wrap;
    logic run_rise;
    logic map_rise;
    logic in_rise;
    logic tick_hit;
    logic ev;
    logic tc;
    logic lat;
    s_d          = s_q;
    map_w        = '0;
    hold_w       = '0;
    clr_w        = '0;
    wrap         = 1'b0;
    run_rise     = 1'b0;
    map_rise     = 1'b0;
    in_rise      = 1'b0;
    tick_hit     = 1'b0;
    ev           = 1'b0;
    tc           = 1'b0;
    lat          = 1'b0;
    s_d.sync1    = CH_PIN;
    s_d.sync2    = s_q.sync1;
    s_d.deb_prev = deb;
    s_d.run_prev = ACQ_RUN;
    s_d.snap_stb = '0;

    // Scan timing
    run_rise = ACQ_RUN && !s_q.run_prev;
    wrap     = 33'(s_q.scan) + 33'h1 >= 33'(SCAN_PERIOD);
    if (!ACQ_RUN)
    begin
      s_d.scan  = '0;
      s_d.sos   = 1'b0;
      s_d.first = 1'b0;
    end
    else
    begin
      s_d.sos   = run_rise || wrap;
      s_d.first = run_rise;
      s_d.scan  = (run_rise || wrap) ? 32'h0 : 32'(s_q.scan + 32'h1);
    end

    // Counters
    for (int i = 0; i < `CDFE_CHANNELS; i++)
    begin
      map_w[i]        = deb[CTR_CFG[i].map_sel];
      s_d.map_prev[i] = map_w[i];
      map_rise        = map_w[i] && !s_q.map_prev[i];
      in_rise         = deb[i] && !s_q.deb_prev[i];
      tick_hit = s_q.tick[i] + `CDFE_TICK_W'h1 >=
        TICK_LIM[CTR_CFG[i].tick_sel];
      s_d.tick[i] = tick_hit ? '0 :
        `CDFE_TICK_W'(s_q.tick[i] + `CDFE_TICK_W'h1);
      ev = CTR_CFG[i].tick_src ? tick_hit : in_rise;
      tc = CTR_CFG[i].wide ? (s_q.cnt[i] == `CDFE_MAX32) :
        (s_q.cnt[i][15:0] == `CDFE_MAX16);
      clr_w[i] = (s_q.sos && s_q.first)
        || (s_q.sos && CTR_CFG[i].sos_clr)
        || (CTR_CFG[i].map_clr_en && map_rise);
      hold_w[i] = CTR_CFG[i].gate_en && !map_w[i];
      lat = CTR_CFG[i].map_latch ? map_rise : s_q.sos;
      if (lat)
      begin
        s_d.snap[i]     = s_q.cnt[i];
        s_d.snap_stb[i] = 1'b1;
      end
      // Clear wins over a count in the same cycle
      if (clr_w[i])
      begin
        s_d.cnt[i]  = `CDFE_CNT_RST;
        s_d.tick[i] = '0;
      end
      else if (ev && !hold_w[i] && !(tc && CTR_CFG[i].stop_top))
      begin
        if (CTR_CFG[i].wide)
          s_d.cnt[i] = 32'(s_q.cnt[i] + 32'h1);
        else
          s_d.cnt[i] = {16'h0, 16'(s_q.cnt[i][15:0] + 16'h1)};
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign DEB_OUT   = deb;
  assign SOS_PULSE = s_q.sos;
  assign CTR_VALUE = s_q.cnt;
  assign CTR_SNAP  = s_q.snap;
  assign SNAP_STB  = s_q.snap_stb;

  for (genvar t = 0; t < `CDFE_CHANNELS; t++)
  begin : g_tc
    assign TERM_CNT[t] = CTR_CFG[t].wide ?
      (s_q.cnt[t] == `CDFE_MAX32) : (s_q.cnt[t][15:0] == `CDFE_MAX16);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sos_single: assert property (@(posedge CORE_CLK) disable iff (RST)
    SOS_PULSE && ACQ_RUN && $stable(ACQ_RUN) && SCAN_PERIOD > 32'h1
    |=> !SOS_PULSE)
    else $error("start of scan longer than one cycle");
  a_sos_start: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(ACQ_RUN) |=> SOS_PULSE && s_q.first)
    else $error("no start of scan after run");

  for (genvar a = 0; a < `CDFE_CHANNELS; a++)
  begin : g_chk
    a_gate_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
      hold_w[a] && !clr_w[a] |=> $stable(CTR_VALUE[a]))
      else $error("gated counter moved");
    a_first_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
      SOS_PULSE && s_q.first |=> CTR_VALUE[a] == `CDFE_CNT_RST)
      else $error("first scan did not zero counter");
    a_sos_latch: assert property (@(posedge CORE_CLK) disable iff (RST)
      SOS_PULSE && !CTR_CFG[a].map_latch
      |=> SNAP_STB[a] && CTR_SNAP[a] == $past(CTR_VALUE[a]))
      else $error("start of scan did not latch count");
    a_stop_top: assert property (@(posedge CORE_CLK) disable iff (RST)
      TERM_CNT[a] && CTR_CFG[a].stop_top && !clr_w[a]
      |=> $stable(CTR_VALUE[a]))
      else $error("counter wrapped at top");
  end

  // ****************************************************************
  // Scan and counter checks
  // ****************************************************************
  a_run_stop: assert property (@(posedge CORE_CLK) disable iff (RST)
    !ACQ_RUN |=> !SOS_PULSE)
    else $error("start of scan while stopped");
  a_first_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_q.first |-> SOS_PULSE)
    else $error("first scan flag without start of scan");

  for (genvar b = 0; b < `CDFE_CHANNELS; b++)
  begin : g_cnt_chk
    a_snap_keep: assert property (@(posedge CORE_CLK) disable iff (RST)
      !SNAP_STB[b] |-> $stable(CTR_SNAP[b]))
      else $error("latched count moved without strobe");

    a_latch_map: assert property (@(posedge CORE_CLK) disable iff (RST)
      CTR_CFG[b].map_latch && map_w[b] && !s_q.map_prev[b]
      |=> SNAP_STB[b] && CTR_SNAP[b] == $past(CTR_VALUE[b]))
      else $error("mapped edge did not latch count");

    a_map_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      CTR_CFG[b].map_clr_en && map_w[b] && !s_q.map_prev[b]
      |=> CTR_VALUE[b] == `CDFE_CNT_RST)
      else $error("mapped edge did not clear counter");

    a_sos_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      SOS_PULSE && CTR_CFG[b].sos_clr |=> CTR_VALUE[b] == `CDFE_CNT_RST)
      else $error("start of scan did not clear counter");

    // Modulo difference also covers the wrap from the top
    a_count_one: assert property (@(posedge CORE_CLK) disable iff (RST)
      CTR_CFG[b].wide && !clr_w[b]
      |=> 32'(CTR_VALUE[b] - $past(CTR_VALUE[b])) <= 32'h1)
      else $error("counter stepped by more than one");

    a_upper_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
      !CTR_CFG[b].wide && CTR_VALUE[b][31:16] == 16'h0
      |=> CTR_VALUE[b][31:16] == 16'h0)
      else $error("narrow counter touched upper half");

    // A select change may leave one stale tick, so check once settled
    a_tick_range: assert property (@(posedge CORE_CLK) disable iff (RST)
      $stable(CTR_CFG[b].tick_sel)
      |-> s_q.tick[b] < TICK_LIM[CTR_CFG[b].tick_sel])
      else $error("tick prescaler beyond its limit");

    a_tick_only: assert property (@(posedge CORE_CLK) disable iff (RST)
      CTR_CFG[b].tick_src && !clr_w[b]
      && s_q.tick[b] + `CDFE_TICK_W'h1 < TICK_LIM[CTR_CFG[b].tick_sel]
      |=> $stable(CTR_VALUE[b]))
      else $error("tick counter moved between ticks");
  end

  c_gate_hold: cover property (@(posedge CORE_CLK) hold_w[0] && !clr_w[0]);
  c_term_cnt: cover property (@(posedge CORE_CLK) TERM_CNT[0]);
  c_map_clear: cover property (@(posedge CORE_CLK)
    CTR_CFG[1].map_clr_en && clr_w[1] && !SOS_PULSE);

endmodule // cdfe_top

`default_nettype wire

/* hdl/cdfe_defines.svh */
// Constants for the counter input debounce front end
// Assumes a 50 ns core clock and a 48 MHz system timebase reference
`ifndef CDFE_DEFINES_SVH
`define CDFE_DEFINES_SVH

// ****************************************************************
// Clock and timebase
// ****************************************************************
`define CDFE_CLK_NS      50
`define CDFE_SYS_MHZ     48
`define CDFE_TICK_W      10

// ****************************************************************
// Debounce table
// ****************************************************************
`define CDFE_DB_MIN_NS   500
`define CDFE_DB_MAX_NS   25500000
`define CDFE_DB_W        20
`define CDFE_DB_LAST     4'hf

// ****************************************************************
// Counter terminal values and resets
// ****************************************************************
`define CDFE_MAX16       16'hffff
`define CDFE_MAX32       32'hffffffff
`define CDFE_CNT_RST     32'h00000000
`define CDFE_CHANNELS    4

`endif

/* hdl/cdfe_pkg.sv */
// Types shared by the debounce stage and the front end top
// Assumes cdfe_defines.svh is compiled alongside
`include "cdfe_defines.svh"

package cdfe_pkg;

  typedef enum logic {CDFE_SETTLE, CDFE_PASS} cdfe_mode_type;

  typedef struct packed {
    logic          invert;
    logic          bypass;
    cdfe_mode_type mode;
    logic [3:0]    db_sel;
  } cdfe_ch_cfg_type;

  typedef struct packed {
    logic [1:0] map_sel;
    logic       gate_en;
    logic       map_clr_en;
    logic       map_latch;
    logic       sos_clr;
    logic       stop_top;
    logic       wide;
    logic       tick_src;
    logic [1:0] tick_sel;
  } cdfe_ctr_cfg_type;

  typedef struct packed {
    logic                  last;
    logic                  out;
    logic [`CDFE_DB_W-1:0] cnt;
  } cdfe_db_state_type;

  typedef struct packed {
    logic [3:0]                  sync1;
    logic [3:0]                  sync2;
    logic [3:0]                  deb_prev;
    logic [3:0]                  map_prev;
    logic [3:0][31:0]            cnt;
    logic [3:0][31:0]            snap;
    logic [3:0]                  snap_stb;
    logic [3:0][`CDFE_TICK_W-1:0] tick;
    logic [31:0]                 scan;
    logic                        run_prev;
    logic                        sos;
    logic                        first;
  } cdfe_top_state_type;

endpackage

/* hdl/cdfe_debounce.sv */
// One channel debounce stage: settle-then-pass, pass-then-settle, bypass
// Assumes din_i is already synchronised and edge-selected by the caller
`timescale 1ns/1ps
`default_nettype none
`include "cdfe_defines.svh"

module cdfe_debounce
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  din_i,
  input  wire logic                  bypass_i,
  input  wire cdfe_pkg::cdfe_mode_type mode_i,
  input  wire logic [`CDFE_DB_W-1:0] limit_i,
  output logic                       out_o
);

  cdfe_pkg::cdfe_db_state_type s_q;
  cdfe_pkg::cdfe_db_state_type s_d;
  logic                        changed;
  logic                        stable;
  logic                        settle_act;
  logic                        pass_act;

  assign changed    = din_i != s_q.last;
  assign stable     = s_q.cnt >= limit_i;
  assign settle_act = !bypass_i && mode_i == cdfe_pkg::CDFE_SETTLE;
  assign pass_act   = !bypass_i && mode_i == cdfe_pkg::CDFE_PASS;
  assign out_o      = s_q.out;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d      = s_q;
    s_d.last = din_i;
    // Saturate so a long quiet input never wraps back to unstable
    if (changed)
      s_d.cnt = '0;
    else if (!stable)
      s_d.cnt = `CDFE_DB_W'(s_q.cnt + `CDFE_DB_W'h1);
    if (bypass_i)
      s_d.out = din_i;
    else if (settle_act)
    begin
      if (stable && s_q.last != s_q.out)
        s_d.out = s_q.last;
    end
    else
    begin
      if (changed && stable)
        s_d.out = din_i;
      else if (stable && s_q.last != s_q.out)
        s_d.out = s_q.last;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_bypass_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(bypass_i) |-> out_o == $past(din_i))
    else $error("bypass output did not follow input");
  a_settle_pass: assert property (@(posedge clk) disable iff (rst)
    settle_act && stable && s_q.last != s_q.out |=> out_o == $past(s_q.last))
    else $error("settled level not passed");
  a_settle_reject: assert property (@(posedge clk) disable iff (rst)
    settle_act && !stable |=> $stable(out_o))
    else $error("unsettled input changed output");
  a_pass_edge: assert property (@(posedge clk) disable iff (rst)
    pass_act && stable && changed |=> out_o == $past(din_i))
    else $error("accepted edge not passed at once");
  a_pass_reject: assert property (@(posedge clk) disable iff (rst)
    pass_act && !stable |=> $stable(out_o))
    else $error("edge accepted without prior stability");
  c_pass_edge: cover property (@(posedge clk) pass_act && stable && changed);
  c_settle_done: cover property (@(posedge clk)
    settle_act && stable && s_q.last != s_q.out);

endmodule // cdfe_debounce

`default_nettype wire

/* tb/cdfe_top_bench.sv */
// Bench for the counter input front end: debounce, scan, counters
// Assumes cdfe_pkg and cdfe_defines.svh are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module cdfe_top_bench;
  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic                          clk;
  logic                          rst;
  logic [3:0]                    pin;
  cdfe_pkg::cdfe_ch_cfg_type [3:0]  ch_cfg;
  cdfe_pkg::cdfe_ctr_cfg_type [3:0] ctr_cfg;
  logic                          run;
  logic [31:0]                   period;
  logic [3:0]                    deb;
  logic                          sos;
  logic [3:0][31:0]              val;
  logic [3:0][31:0]              snap;
  logic [3:0]                    stb;
  logic [3:0]                    term;
  int                            n_fail;
  int                            compares;
  int                            mdl;
  int                            n;
  int                            lim;
  int                            tk[4] = '{1, 4, 41, 416};
  logic [15:0]                   a;
  logic [31:0]                   v;
  logic [3:0]                    inv;

  // Short limits keep the 25.5 ms setting affordable in simulation
  cdfe_top #(.DB_MIN_CYC(2), .DB_MAX_CYC(64)) cdfe_top_i
  (
    .CORE_CLK    (clk),
    .RST         (rst),
    .CH_PIN      (pin),
    .CH_CFG      (ch_cfg),
    .CTR_CFG     (ctr_cfg),
    .ACQ_RUN     (run),
    .SCAN_PERIOD (period),
    .DEB_OUT     (deb),
    .SOS_PULSE   (sos),
    .CTR_VALUE   (val),
    .CTR_SNAP    (snap),
    .SNAP_STB    (stb),
    .TERM_CNT    (term)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic drv(input int c, input logic x);
    @(posedge clk);
    pin[c] <= x;
  endtask

  // Sampled on falling edges, clear of the launching edge
  task automatic wait_sig(input int s, input int i, input logic x,
                          input int bound, output int k);
    logic q;
    k = 0;
    while (k < bound)
    begin
      q = (s == 0) ? deb[i] : (s == 1) ? sos : stb[i];
      if (q === x)
        break;
      @(negedge clk);
      k++;
    end
    if (k >= bound)
    begin
      chk(1'b0, "wait timed out");
      finish_test();
    end
  endtask

  task automatic hold_chk(input int c, input logic x, input int k);
    repeat (k)
    begin
      @(negedge clk);
      chk(deb[c] === x, "debounced output moved");
    end
  endtask

  task automatic pulse0(input int gate);
    drv(0, 1'b1);
    cyc(3);
    drv(0, 1'b0);
    cyc(3);
    if (gate != 0)
      mdl++;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    pin = 4'h0;
    ch_cfg = '0;
    ctr_cfg = '0;
    run = 1'b0;
    period = 32'h00000000;
    n_fail = 0;
    compares = 0;
    mdl = 0;
    void'($urandom(32'hf5cb));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Bypass with random inversion and ignored time select
    repeat (12)
    begin
      v = $urandom;
      inv = v[7:4];
      @(posedge clk);
      pin <= v[3:0];
      for (int c = 0; c < 4; c++)
        ch_cfg[c] <= '{inv[c], 1'b1, cdfe_pkg::cdfe_mode_type'(v[8]), v[12:9]};
      cyc(4);
      chk(deb === (v[3:0] ^ inv), "bypass level");
    end
    // Settle mode over time selects 0 to 7 and 15, both edges
    @(posedge clk);
    pin <= 4'h0;
    ch_cfg[0] <= '{1'b0, 1'b0, cdfe_pkg::CDFE_SETTLE, 4'h0};
    cyc(80);
    for (int k = 0; k < 9; k++)
    begin
      lim = (k == 8) ? 64 : (2 << k);
      @(posedge clk);
      ch_cfg[0].db_sel <= (k == 8) ? 4'hf : 4'(k);
      drv(0, 1'b1);
      wait_sig(0, 0, 1'b1, lim + 12, n);
      chk(n >= lim, "rise passed early");
      drv(0, 1'b0);
      wait_sig(0, 0, 1'b0, lim + 12, n);
      chk(n >= lim, "fall passed early");
    end
    // Disturbance shorter than 16 cycles never passes
    @(posedge clk);
    ch_cfg[0].db_sel <= 4'h3;
    repeat (4)
    begin
      drv(0, 1'b1);
      hold_chk(0, 1'b0, 5);
      drv(0, 1'b0);
      hold_chk(0, 1'b0, 5);
    end
    // Pass mode: first edge at once, bounce ignored
    @(posedge clk);
    ch_cfg[0].mode <= cdfe_pkg::CDFE_PASS;
    cyc(40);
    drv(0, 1'b1);
    wait_sig(0, 0, 1'b1, 5, n);
    drv(0, 1'b0);
    hold_chk(0, 1'b1, 3);
    drv(0, 1'b1);
    hold_chk(0, 1'b1, 30);
    drv(0, 1'b0);
    wait_sig(0, 0, 1'b0, 5, n);
    // Counters: gated edges, tick rates, mapped clear, saturation
    @(posedge clk);
    for (int c = 0; c < 4; c++)
      ch_cfg[c] <= '{1'b0, 1'b1, cdfe_pkg::CDFE_SETTLE, 4'h0};
    ctr_cfg[0] <= '{2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0};
    ctr_cfg[1] <= '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0};
    ctr_cfg[2] <= '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0};
    ctr_cfg[3] <= '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0};
    lim = 300 + ($urandom % 100);
    period <= 32'(lim);
    cyc(20);
    @(posedge clk);
    run <= 1'b1;
    wait_sig(1, 0, 1'b1, 10, n);
    cyc(1);
    chk(val[2] === 32'h0, "first scan clear");
    wait_sig(1, 0, 1'b1, lim + 5, n);
    chk(n == lim - 1, "scan period");
    drv(1, 1'b1);
    cyc(8);
    chk(val[3] < 32'd12, "mapped clear");
    chk(snap[3] === 32'(lim + 3), "mapped latch");
    repeat (3) pulse0(1);
    drv(1, 1'b0);
    cyc(5);
    repeat (2) pulse0(0);
    chk(val[0] === 32'(mdl), "gated count");
    wait_sig(2, 0, 1'b1, lim, n);
    chk(snap[0] === 32'(mdl), "latched count");
    chk(val[0] === 32'h0, "scan clear");
    @(posedge clk);
    period <= 32'h00100000;
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clk);
      ctr_cfg[1].tick_sel <= 2'(t);
      cyc(900);
      a = val[1][15:0];
      cyc(1664);
      n = int'(16'(val[1][15:0] - a));
      lim = 1664 / tk[t];
      chk(n >= lim - 1 && n <= lim + 1, "tick rate");
    end
    cyc(60000);
    chk(val[2] === 32'h0000ffff, "stop at top");
    chk(term[2] === 1'b1, "terminal count");
    chk(val[1][31:16] === 16'h0, "narrow upper half");
    finish_test();
  end
endmodule // cdfe_top_bench

`default_nettype wire
